// ===== logic/xpt_pkg.sv
// Shared constants and types for the crosspoint serial control logic
package xpt_pkg;

   // Matrix geometry and the two word formats
   localparam int NUM_OUT = 8;
   localparam int IDX_W = 4;
   localparam int FIELD_W = 5;
   localparam int FRAME_BITS = 40;
   localparam int WORD_BITS = 8;
   localparam int SEL_W = NUM_OUT * IDX_W;
   // Field of one output inside a frame slot
   localparam int SLOT_IDX_LSB = 0;
   localparam int SLOT_OFF_POS = 4;
   // Field positions inside an addressed word
   localparam int WORD_ADDR_LSB = 0;
   localparam int WORD_ADDR_W = 3;
   localparam int WORD_IDX_LSB = 3;
   localparam int WORD_OFF_POS = 7;
   // Slot value after reset: input index 0, output off
   localparam logic [4:0] SLOT_RST = 5'h10;
   localparam logic [7:0] WORD_RST = 8'h00;
   localparam logic [6:0] CNT_RST = 7'h00;
   localparam logic [6:0] CNT_MAX = 7'h7f;
   localparam logic [6:0] CNT_WORD = 7'h08;

   // Pin synchroniser: {fanout, reset, mode, cfg, din, cs_n, sclk}
   localparam int SYNC_W = 7;
   localparam logic [6:0] SYNC_INIT = 7'h02;

   // Register bus
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] STAGED_LO_OFF = 8'h08;
   localparam logic [7:0] STAGED_HI_OFF = 8'h0c;
   localparam logic [7:0] ACTIVE_LO_OFF = 8'h10;
   localparam logic [7:0] ACTIVE_HI_OFF = 8'h14;
   localparam int CTRL_RST_POS = 0;
   localparam int CTRL_FAN_POS = 1;
   localparam int CTRL_CFG_POS = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Serial link states
   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_ARMED = 2'b01,
      LS_SHIFT = 2'b10,
      LS_CLOSE = 2'b11
   } link_state_type;

endpackage

// ===== logic/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] pins, // Raw pin levels
   output logic [WIDTH-1:0] synced // Levels after two flops
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] held;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   if (WIDTH < 1) begin : g_check
      $error("pin_sync needs WIDTH of at least one");
   end

   // Meta stage feeds only the held stage
   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = pins;
      s_nxt.held = s_r.meta;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r.meta <= INIT;
         s_r.held <= INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign synced = s_r.held;

endmodule

// ===== logic/crosspoint_serial_control.sv
// Serial programming logic of a 16-input, 8-output crosspoint switch
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module crosspoint_serial_control (
   input wire logic aclk, // System clock, 250 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic sclk, // Serial clock from host
   input wire logic cs_n, // Serial select, active low
   input wire logic din, // Serial data in
   input wire logic cfg, // Configure strobe, active high
   input wire logic mode, // High: addressed words, low: frames
   input wire logic rst, // Matrix reset pin, active high
   input wire logic fanout_input_zero, // All outputs on input 0
   output logic dout, // Serial data out to next device
   output logic [31:0] out_sel, // Input index, four bits per output
   output logic [7:0] out_on, // Output enabled, one bit per output
   input wire logic [7:0] awaddr, // AXI write address
   input wire logic awvalid, // AXI write address valid
   output logic awready, // AXI write address ready
   input wire logic [31:0] wdata, // AXI write data
   input wire logic [3:0] wstrb, // AXI write strobes
   input wire logic wvalid, // AXI write data valid
   output logic wready, // AXI write data ready
   output logic [1:0] bresp, // AXI write response
   output logic bvalid, // AXI write response valid
   input wire logic bready, // AXI write response ready
   input wire logic [7:0] araddr, // AXI read address
   input wire logic arvalid, // AXI read address valid
   output logic arready, // AXI read address ready
   output logic [31:0] rdata, // AXI read data
   output logic [1:0] rresp, // AXI read response
   output logic rvalid, // AXI read data valid
   input wire logic rready // AXI read data ready
);

   typedef struct packed {
      xpt_pkg::link_state_type ls;
      logic sclk_d, cfg_d;
      logic [39:0] frame;
      logic [7:0] word;
      logic [6:0] cnt;
      logic [39:0] matrix;
      logic pending;
      logic [31:0] sel;
      logic [7:0] on;
      logic soft_rst, soft_fan, soft_cfg;
      logic aw_got, w_got;
      logic [7:0] waddr;
      logic [31:0] wbuf;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_type;

   state_type s_r;
   state_type s_nxt;
   logic [6:0] pins_s;
   logic sclk_s, cs_n_s, din_s, cfg_s, mode_s, rst_s, fan_s;
   logic rise, fall, cfg_evt, rst_eff, fan_eff;
   logic [7:0] wa, ra;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   pin_sync #(
      .WIDTH(xpt_pkg::SYNC_W),
      .INIT(xpt_pkg::SYNC_INIT)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins({fanout_input_zero, rst, mode, cfg, din, cs_n, sclk}),
      .synced(pins_s)
   );

   // Serial clock edges; clock runs far slower than aclk
   assign {fan_s, rst_s, mode_s, cfg_s, din_s, cs_n_s, sclk_s} = pins_s;
   assign rise = sclk_s && !s_r.sclk_d;
   assign fall = !sclk_s && s_r.sclk_d;
   assign cfg_evt = (cfg_s && !s_r.cfg_d) || s_r.soft_cfg;
   assign rst_eff = rst_s || s_r.soft_rst;
   assign fan_eff = fan_s || s_r.soft_fan;
   assign wa = {s_r.waddr[7:2], 2'b00};
   assign ra = {araddr[7:2], 2'b00};

   // Bus handshakes: one write and one read in flight at most
   assign awready = !s_r.aw_got && !s_r.bvalid;
   assign wready = !s_r.w_got && !s_r.bvalid;
   assign arready = !s_r.rvalid;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.soft_cfg = 1'b0;
      s_nxt.sclk_d = sclk_s;
      s_nxt.cfg_d = cfg_s;

      // Write channel: address and data taken in either order
      if (awvalid && awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.waddr = awaddr;
      end
      if (wvalid && wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wbuf = wdata;
         s_nxt.wstrb0 = wstrb[0];
      end
      if (s_r.aw_got && s_r.w_got) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = xpt_pkg::RESP_OKAY;
         case (wa)
            xpt_pkg::CTRL_OFF: begin
               if (s_r.wstrb0) begin
                  s_nxt.soft_rst = s_r.wbuf[xpt_pkg::CTRL_RST_POS];
                  s_nxt.soft_fan = s_r.wbuf[xpt_pkg::CTRL_FAN_POS];
                  s_nxt.soft_cfg = s_r.wbuf[xpt_pkg::CTRL_CFG_POS];
               end
            end
            // Read-only registers ignore writes
            xpt_pkg::STATUS_OFF, xpt_pkg::STAGED_LO_OFF,
            xpt_pkg::STAGED_HI_OFF, xpt_pkg::ACTIVE_LO_OFF,
            xpt_pkg::ACTIVE_HI_OFF: begin
               s_nxt.bresp = xpt_pkg::RESP_OKAY;
            end
            default: begin
               s_nxt.bresp = xpt_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // Read channel: data registered at the address edge
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = xpt_pkg::RESP_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         case (ra)
            xpt_pkg::CTRL_OFF: begin
               s_nxt.rdata[xpt_pkg::CTRL_RST_POS] = s_r.soft_rst;
               s_nxt.rdata[xpt_pkg::CTRL_FAN_POS] = s_r.soft_fan;
            end
            xpt_pkg::STATUS_OFF: begin
               s_nxt.rdata[14:0] = {s_r.cnt, 1'b0, s_r.ls, fan_s, rst_s,
                                    cs_n_s, mode_s, s_r.pending};
            end
            xpt_pkg::STAGED_LO_OFF: s_nxt.rdata = s_r.frame[31:0];
            xpt_pkg::STAGED_HI_OFF: s_nxt.rdata[7:0] = s_r.frame[39:32];
            xpt_pkg::ACTIVE_LO_OFF: s_nxt.rdata = s_r.matrix[31:0];
            xpt_pkg::ACTIVE_HI_OFF: s_nxt.rdata[7:0] = s_r.matrix[39:32];
            default: begin
               s_nxt.rresp = xpt_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Configure copies staged bank to matrix; pulse without new data
      // is a no-op. Set below wins over this clear.
      if (cfg_evt && s_r.pending) begin
         s_nxt.matrix = s_r.frame;
         s_nxt.pending = 1'b0;
      end
      // Serial link; host keeps select changes inside clock-low time
      case (s_r.ls)
         xpt_pkg::LS_IDLE: begin
            if (!cs_n_s) begin
               s_nxt.ls = xpt_pkg::LS_ARMED;
               s_nxt.cnt = xpt_pkg::CNT_RST;
            end
         end
         xpt_pkg::LS_ARMED: begin
            if (cs_n_s) begin
               s_nxt.ls = xpt_pkg::LS_IDLE;
            end else if (rise) begin
               s_nxt.ls = xpt_pkg::LS_SHIFT;
            end
         end
         xpt_pkg::LS_SHIFT: begin
            if (cs_n_s) begin
               s_nxt.ls = xpt_pkg::LS_CLOSE;
            end else if (fall) begin
               // Falling edge capture; bit 0 first, ends in slot bit 0
               if (s_r.cnt != xpt_pkg::CNT_MAX) begin
                  s_nxt.cnt = s_r.cnt + 7'h01;
               end
               if (mode_s) begin
                  s_nxt.word = {din_s, s_r.word[7:1]};
               end else begin
                  // Staged bank is itself the shift path
                  s_nxt.frame = {din_s, s_r.frame[39:1]};
               end
            end
         end
         xpt_pkg::LS_CLOSE: begin
            // Word ends at the first rise after deselect
            if (rise) begin
               s_nxt.ls = xpt_pkg::LS_IDLE;
               if (mode_s && s_r.cnt == xpt_pkg::CNT_WORD) begin
                  for (int i = 0; i < xpt_pkg::NUM_OUT; i++) begin
                     if (s_r.word[2:0] == i[2:0]) begin
                        s_nxt.frame[i*5 +: 5] = s_r.word[7:3];
                     end
                  end
                  s_nxt.pending = 1'b1;
               end else if (!mode_s && s_r.cnt != xpt_pkg::CNT_RST) begin
                  s_nxt.pending = 1'b1;
               end
            end
         end
         default: begin
            s_nxt.ls = xpt_pkg::LS_IDLE;
         end
      endcase
      // Reset pin clears both banks whatever the serial port does
      if (rst_eff) begin
         s_nxt.ls = xpt_pkg::LS_IDLE;
         s_nxt.cnt = xpt_pkg::CNT_RST;
         s_nxt.word = xpt_pkg::WORD_RST;
         s_nxt.pending = 1'b0;
         s_nxt.frame = {xpt_pkg::NUM_OUT{xpt_pkg::SLOT_RST}};
         s_nxt.matrix = {xpt_pkg::NUM_OUT{xpt_pkg::SLOT_RST}};
      end

      // Output drive; reset beats fanout, fanout beats the matrix
      for (int i = 0; i < xpt_pkg::NUM_OUT; i++) begin
         if (rst_eff) begin
            s_nxt.sel[i*4 +: 4] = 4'h0;
            s_nxt.on[i] = 1'b0;
         end else if (fan_eff) begin
            s_nxt.sel[i*4 +: 4] = 4'h0;
            s_nxt.on[i] = 1'b1;
         end else begin
            s_nxt.sel[i*4 +: 4] = s_r.matrix[i*5 +: 4];
            s_nxt.on[i] = !s_r.matrix[i*5 + xpt_pkg::SLOT_OFF_POS];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.frame <= {xpt_pkg::NUM_OUT{xpt_pkg::SLOT_RST}};
         s_r.matrix <= {xpt_pkg::NUM_OUT{xpt_pkg::SLOT_RST}};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Oldest staged bit feeds the next device in both modes; only frame mode shifts it
   assign dout = s_r.frame[0];
   assign out_sel = s_r.sel;
   assign out_on = s_r.on;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign rvalid = s_r.rvalid;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Link steps shared by the properties below
   sequence seq_shift_bit;
      s_r.ls == xpt_pkg::LS_SHIFT && !cs_n_s && fall && !rst_eff;
   endsequence
   sequence seq_word_close;
      s_r.ls == xpt_pkg::LS_CLOSE && rise && mode_s && !rst_eff;
   endsequence
   a_reset_all_off: assert property (
      rst_eff |=> out_on == 8'h00 && out_sel == 32'h0000_0000 &&
                  s_r.matrix == {xpt_pkg::NUM_OUT{xpt_pkg::SLOT_RST}})
      else $error("reset did not turn all outputs off");
   a_fanout_all_on: assert property (
      !rst_eff && fan_eff |=> out_on == 8'hff && out_sel == 32'h0000_0000)
      else $error("fanout did not route input zero to all outputs");
   a_reset_beats_fan: assert property (
      rst_eff && fan_eff |=> out_on == 8'h00)
      else $error("fanout overrode reset");
   a_cfg_loads_matrix: assert property (
      cfg_evt && s_r.pending && !rst_eff |=>
         s_r.matrix == $past(s_r.frame))
      else $error("configure did not load staged data");
   a_matrix_holds: assert property (
      !(cfg_evt && s_r.pending) && !rst_eff |=> $stable(s_r.matrix))
      else $error("matrix changed without configure");
   a_idle_ignores: assert property (
      s_r.ls == xpt_pkg::LS_IDLE && !rst_eff |=> $stable(s_r.frame))
      else $error("staged data moved while deselected");
   a_sync_first: assert property (
      s_r.ls == xpt_pkg::LS_ARMED && !cs_n_s && rise && !rst_eff |=>
         s_r.ls == xpt_pkg::LS_SHIFT && s_r.cnt == 7'h00)
      else $error("first rise did not arm the shifter");
   a_dout_oldest: assert property (
      seq_shift_bit ##0 !mode_s |=> dout == $past(s_r.frame[1]) &&
         s_r.frame[39] == $past(din_s))
      else $error("frame shift did not move oldest bit out");
   // Host may reselect soon after, so only the closing cycle is checked
   a_word_lands: assert property (
      seq_word_close ##0 s_r.cnt == 7'h08 |=> s_r.pending &&
         s_r.ls == xpt_pkg::LS_IDLE)
      else $error("complete addressed word not staged");
   a_short_word_dropped: assert property (
      seq_word_close ##0 s_r.cnt != 7'h08 |=> $stable(s_r.frame))
      else $error("short addressed word changed staging");
   a_out_follows: assert property (
      !rst_eff && !fan_eff |=> out_sel[31:28] == $past(s_r.matrix[38:35])
         && out_on[7] == !$past(s_r.matrix[39]))
      else $error("outputs do not follow the matrix");
endmodule

// ===== bench/serial_host.sv
// Host model driving the serial programming port of the crosspoint
`timescale 1ns/10ps
module serial_host (
   input wire logic aclk, // Bench system clock
   output logic sclk, // Serial clock, 160 ns period, 320 ns for the slow words
   output logic cs_n, // Select, active low
   output logic din, // Serial data to the device
   input wire logic dout // Serial data back from the device
);
   logic [79:0] seen; // Device output just before each fall

   ////////////////////////////////////////////////////////////////////////
   // Idle pins: clock stands still outside transfers and noise bursts
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      seen = '0;
   end

   task wait_c(input int n);
      repeat (n) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // One transfer of n bits, bit 0 first; slow stretches the low phases
   task shift(input logic [79:0] bits, input int n, input int slow);
      cs_n <= 1'b0;
      wait_c(20 + slow);
      sclk <= 1'b1; // Sync rise before any data
      for (int i = 0; i < n; i++) begin
         wait_c(10);
         din <= bits[i];
         seen[i] <= dout; // Oldest staged bit
         wait_c(10);
         sclk <= 1'b0; // Capture edge
         wait_c(10 + slow);
         if (i == n - 1) cs_n <= 1'b1; // Deselect while low
         wait_c(10);
         sclk <= 1'b1; // Last pass is the closing rise
      end
      wait_c(20);
      sclk <= 1'b0;
      din <= ~din; // Released line must not keep a stale level
      wait_c(10); // Clock settles low before any new select
   endtask

   // Whole frame, only ever used in frame mode
   task frame(input logic [39:0] f);
      shift({40'h00_0000_0000, f}, 40, 0);
   endtask

   // Two-device chain: 80 bits, then both selects rise together
   task chain(input logic [79:0] f);
      shift(f, 80, 0);
   endtask

   task word(input logic [7:0] w, input int slow);
      shift({72'h00_0000_0000_0000_0000, w}, 8, slow);
   endtask

   // Deliberately short addressed word
   task word7(input logic [6:0] w);
      shift({73'h000_0000_0000_0000_0000, w}, 7, 0);
   endtask

   // Clock and data toggling while deselected
   task noise(input int n);
      for (int i = 0; i < n; i++) begin
         din <= ~din;
         sclk <= 1'b1;
         wait_c(20);
         sclk <= 1'b0;
         wait_c(20);
      end
   endtask
endmodule

// ===== bench/test_crosspoint_serial_control.sv
// Self-checking bench for the crosspoint serial control block
`timescale 1ns/10ps
module test_crosspoint_serial_control;
   logic aclk, aresetn, sclk, cs_n, din, cfg, mode, rst, dout;
   logic fanout_input_zero, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] out_sel, wdata, rdata, d;
   logic [7:0] out_on, awaddr, araddr;
   logic [3:0] wstrb, idx;
   logic [1:0] bresp, rresp, r;
   logic [39:0] f, f1, f2;
   int bad_count, comparisons;
   localparam logic [39:0] F_RST = {8{5'h10}};

   crosspoint_serial_control i_crosspoint_serial_control (.aclk, .aresetn,
      .sclk, .cs_n, .din, .cfg, .mode, .rst, .fanout_input_zero, .dout,
      .out_sel, .out_on, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready);
   serial_host i_serial_host (.aclk, .sclk, .cs_n, .din, .dout);

   ////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   initial aclk = 1'b0;
   always #2 aclk = ~aclk;

   task check(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Both matrix output buses against a frame image
   task check_outs(input logic [39:0] fi);
      logic [31:0] s;
      logic [7:0] e;
      for (int i = 0; i < 8; i++) begin
         s[4*i+:4] = fi[5*i+:4];
         e[i] = ~fi[5*i+4];
      end
      check({8'h00, out_sel}, {8'h00, s});
      check({32'h0000_0000, out_on}, {32'h0000_0000, e});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Register bus; ready and answers sampled at the settled low phase
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw, aw_done, w_done, b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(negedge aclk);
         ta = awready && !aw_done;
         tw = wready && !w_done;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         aw_done = aw_done | ta;
         w_done = w_done | tw;
      end
      do begin
         @(negedge aclk);
         b = bvalid;
         rs = bresp;
         @(posedge aclk);
      end while (!b);
      bready <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         t = rvalid;
         v = rdata;
         rs = rresp;
         @(posedge aclk);
      end while (!t);
      rready <= 1'b0;
   endtask

   // A 40-bit image held in two registers
   task check_pair(input logic [7:0] lo, input logic [39:0] fi);
      rd(lo, d, r);
      check({8'h00, d}, {8'h00, fi[31:0]});
      rd(lo + 8'h04, d, r);
      check({8'h00, d}, {32'h0000_0000, fi[39:32]});
   endtask

   // Strobe only once the transfer has closed
   task pulse_cfg;
      cfg <= 1'b1;
      repeat (4) @(posedge aclk);
      cfg <= 1'b0;
      repeat (10) @(posedge aclk);
   endtask

   task stop_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: about four times the expected run length
   initial begin
      repeat (50000) @(posedge aclk);
      bad_count++;
      stop_test;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {aresetn, cfg, mode, rst, fanout_input_zero} = 5'h00;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      bad_count = 0;
      comparisons = 0;
      f1 = 40'h5a_c3e1_2b97;
      f2 = 40'ha3_1c4d_e560;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      check_outs(F_RST);
      rd(8'h18, d, r);
      check({38'h0, r}, {38'h0, xpt_pkg::RESP_SLVERR});
      wr(xpt_pkg::STATUS_OFF, 32'h0000_001f, r);
      check({38'h0, r}, {38'h0, xpt_pkg::RESP_OKAY});
      wr(8'h18, 32'h0000_0001, r);
      check({38'h0, r}, {38'h0, xpt_pkg::RESP_SLVERR});
      $display("test registers done");
      // Frame stays staged until configured
      i_serial_host.frame(f1);
      check_outs(F_RST);
      // Status: 40 bits counted, select high, new data pending
      rd(xpt_pkg::STATUS_OFF, d, r);
      check({8'h00, d}, 40'h00_0000_2805);
      check_pair(xpt_pkg::STAGED_LO_OFF, f1);
      pulse_cfg;
      check_outs(f1);
      i_serial_host.noise(6);
      pulse_cfg;
      check_outs(f1);
      check_pair(xpt_pkg::STAGED_LO_OFF, f1);
      $display("test frame done");
      // Old frame leaves on the data output while the new one enters
      i_serial_host.frame(f2);
      check(i_serial_host.seen[39:0], f1);
      // First 40 bits of a chain transfer leave for the next device
      i_serial_host.chain({f2, f1});
      check(i_serial_host.seen[39:0], f2);
      check(i_serial_host.seen[79:40], f1);
      check_pair(xpt_pkg::STAGED_LO_OFF, f2);
      wr(xpt_pkg::CTRL_OFF, 32'h0000_0004, r);
      repeat (10) @(posedge aclk);
      check_outs(f2);
      $display("test chain output done");
      // One addressed word per output, odd outputs sent slowly
      mode <= 1'b1;
      f = f2;
      for (int o = 0; o < 8; o++) begin
         idx = 4'(o + 9);
         i_serial_host.word({o[0], idx, o[2:0]}, o[0] ? 40 : 0);
         f[5*o+:5] = {o[0], idx};
         pulse_cfg;
         check_outs(f);
      end
      i_serial_host.word7(7'h05);
      pulse_cfg;
      check_outs(f);
      mode <= 1'b0;
      $display("test addressed done");
      // Special pins override the serial port
      fanout_input_zero <= 1'b1;
      repeat (10) @(posedge aclk);
      check_outs(40'h00_0000_0000);
      rst <= 1'b1;
      i_serial_host.noise(2);
      pulse_cfg;
      check_outs(F_RST);
      fanout_input_zero <= 1'b0;
      repeat (10) @(posedge aclk);
      check_outs(F_RST);
      rst <= 1'b0;
      repeat (10) @(posedge aclk);
      check_pair(xpt_pkg::ACTIVE_LO_OFF, F_RST);
      wr(xpt_pkg::CTRL_OFF, 32'h0000_0002, r);
      repeat (10) @(posedge aclk);
      check_outs(40'h00_0000_0000);
      wr(xpt_pkg::CTRL_OFF, 32'h0000_0000, r);
      repeat (10) @(posedge aclk);
      check_outs(F_RST);
      $display("test special pins done");
      stop_test;
   end
endmodule
